// >>> hw/adc_compare_pkg.sv
// Package for the converter compare stage: widths, codes and timing.
// Assumes a single 50 MHz clock domain.
package adc_compare_pkg;
    localparam int          CLK_HZ          = 50_000_000;
    localparam real         CMP_TIME_US     = 4.44;
    // Longest time: round down, at least one cycle.
    localparam int          CMP_CYCLES_RAW  = int'($floor(CMP_TIME_US * CLK_HZ / 1.0e6));
    localparam int          CMP_CYCLES      = (CMP_CYCLES_RAW < 1) ? 1 : CMP_CYCLES_RAW;
    localparam int          LEVEL_W         = 6;
    localparam int          BUF_W           = 8;
    localparam int          CHAN_W          = 3;
    localparam int          NUM_CHAN        = 6;
    localparam int          REF_W           = 8;
    localparam logic [5:0]  LEVEL_RESET     = 6'h00;
    localparam logic [2:0]  CHAN_RESET      = 3'h0;
    localparam logic [5:0]  KEY_PIN_MASK    = 6'h3c;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_DONE   = 2'b10
    } cmp_state_t;

    typedef struct packed {
        logic        stop_reset;
        logic        enable_reset;
    } reset_evt_t;
endpackage

// >>> hw/adc_compare_block.sv
// Compare stage of a software-driven successive-approximation converter.
// Assumes inputs synchronous to i_clk; the comparator output is a digital
// level presented on i_cmp_above, valid for the reference on o_ref_half.
`timescale 1ns/100ps
`default_nettype none
module adc_compare_block (
    input  wire logic                                  i_clk,          // 50 MHz clock
    input  wire logic                                  i_resetn,       // Power-on reset, low
    input  wire adc_compare_pkg::reset_evt_t           i_reset_evt,    // Stop / enable-pin reset
    input  wire logic                                  i_level_wr,     // Write level from buffer
    input  wire logic [adc_compare_pkg::BUF_W-1:0]     i_data_buffer,  // Data buffer contents
    input  wire logic                                  i_chan_wr,      // Write channel select
    input  wire logic [adc_compare_pkg::CHAN_W-1:0]    i_chan_sel,     // Channel select bits
    input  wire logic                                  i_analog_en,    // Pins to analog mode
    input  wire logic                                  i_flag_rd,      // Read of result flag
    input  wire logic                                  i_cmp_above,    // Comparator: input > ref
    input  wire logic [adc_compare_pkg::NUM_CHAN-1:0]  i_pin_level,    // Digital pin levels
    input  wire logic                                  i_key_halt_en,  // Key halt release armed
    output logic [adc_compare_pkg::REF_W-1:0]          o_ref_half,     // Reference in 1/128 VDD
    output logic [adc_compare_pkg::NUM_CHAN-1:0]       o_pin_route,    // One-hot pin to comparator
    output logic [adc_compare_pkg::NUM_CHAN-1:0]       o_analog_mode,  // Pin in analog mode
    output logic [adc_compare_pkg::NUM_CHAN-1:0]       o_input_latch,  // Port input latches
    output logic                                       o_switch_on,    // Sampling switches closed
    output logic                                       o_flag,         // Compare result flag
    output logic                                       o_flag_valid,   // One-cycle result pulse
    output logic                                       o_halt_release  // Key halt release
);
    localparam int CW = $clog2(adc_compare_pkg::CMP_CYCLES + 1);

    // Elaboration checks: the logic below is written for these widths.
    if (adc_compare_pkg::NUM_CHAN > (1 << adc_compare_pkg::CHAN_W)) begin : g_chan_check
        $error("Too many channels for the select width.");
    end
    if (adc_compare_pkg::LEVEL_W > adc_compare_pkg::BUF_W) begin : g_level_check
        $error("Level wider than the data buffer.");
    end
    if (adc_compare_pkg::REF_W != adc_compare_pkg::LEVEL_W + 2) begin : g_ref_check
        $error("Reference width must be the level width plus two.");
    end

    logic [adc_compare_pkg::LEVEL_W-1:0]   level_q;
    logic [adc_compare_pkg::CHAN_W-1:0]    chan_q;
    logic                                  analog_q;
    adc_compare_pkg::cmp_state_t           state_q;
    logic [CW-1:0]                         cnt_q;
    logic                                  flag_q;
    logic                                  valid_q;
    logic [adc_compare_pkg::NUM_CHAN-1:0]  latch_q;
    logic [adc_compare_pkg::NUM_CHAN-1:0]  route_d;
    logic                                  soft_reset;

    assign soft_reset = i_reset_evt.stop_reset | i_reset_evt.enable_reset;

    // Compare level: upper two buffer bits are dropped.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            level_q <= adc_compare_pkg::LEVEL_RESET;
        end else if (i_level_wr) begin
            level_q <= i_data_buffer[adc_compare_pkg::LEVEL_W-1:0];
        end
    end

    // Reference in half-LSB units: 2n-1 for n>0, zero for n=0.
    always_comb begin
        if (level_q == 6'h00) begin
            o_ref_half = 8'h00;
        end else begin
            o_ref_half = {1'b0, level_q, 1'b0} - 8'h01;
        end
    end

    // Channel select and analog mode; all soft resets return to port mode.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            chan_q   <= adc_compare_pkg::CHAN_RESET;
            analog_q <= 1'b0;
        end else if (soft_reset) begin
            chan_q   <= adc_compare_pkg::CHAN_RESET;
            analog_q <= 1'b0;
        end else begin
            if (i_chan_wr) begin
                chan_q <= i_chan_sel;
            end
            if (i_analog_en != analog_q) begin
                analog_q <= i_analog_en;
            end
        end
    end

    // Codes past the last channel route nothing, so the comparator input floats.
    always_comb begin
        route_d = '0;
        if (analog_q && (int'(chan_q) < adc_compare_pkg::NUM_CHAN)) begin
            route_d[chan_q] = 1'b1;
        end
    end
    assign o_pin_route   = route_d;
    assign o_analog_mode = route_d;

    // Input latches follow their pins except when cut off for analog use.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            latch_q <= '0;
        end else begin
            for (int i = 0; i < adc_compare_pkg::NUM_CHAN; i++) begin
                if (!route_d[i]) begin
                    latch_q[i] <= i_pin_level[i];
                end
            end
        end
    end
    assign o_input_latch = latch_q;
    assign o_halt_release = i_key_halt_en
                          & (|(latch_q & adc_compare_pkg::KEY_PIN_MASK));

    // One comparison per flag read, lasting one instruction time.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= adc_compare_pkg::ST_IDLE;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                adc_compare_pkg::ST_IDLE: begin
                    if (i_flag_rd) begin
                        state_q <= adc_compare_pkg::ST_SAMPLE;
                        cnt_q   <= CW'(adc_compare_pkg::CMP_CYCLES - 1);
                    end
                end
                adc_compare_pkg::ST_SAMPLE: begin
                    if (cnt_q == '0) begin
                        state_q <= adc_compare_pkg::ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                adc_compare_pkg::ST_DONE: begin
                    state_q <= adc_compare_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= adc_compare_pkg::ST_IDLE;
                end
            endcase
        end
    end
    assign o_switch_on = (state_q == adc_compare_pkg::ST_SAMPLE);

    // The flag is only updated at the end of a comparison.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flag_q  <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            if (state_q == adc_compare_pkg::ST_SAMPLE && cnt_q == '0) begin
                flag_q  <= i_cmp_above;
                valid_q <= 1'b1;
            end
        end
    end
    assign o_flag       = flag_q;
    assign o_flag_valid = valid_q;

    // Assertions.
    ref_code_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (level_q != 6'h00) |-> (o_ref_half[0] && (o_ref_half[7:1] == {1'b0, level_q - 6'h01})))
        else $error("Reference does not match the level code.");
    level_load_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_level_wr |=> (level_q == $past(i_data_buffer[5:0])))
        else $error("Level not loaded from buffer.");
    chan_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (analog_q && chan_q == 3'h0) |-> (o_pin_route == 6'h01))
        else $error("Channel zero not routed to pin zero.");
    soft_rst_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        soft_reset |=> (o_analog_mode == 6'h00))
        else $error("Pins not returned to port mode.");
    no_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (state_q == adc_compare_pkg::ST_IDLE && !i_flag_rd) |=> !o_switch_on)
        else $error("Comparison started without a read.");
    cmp_time_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(o_switch_on) |-> ##[1:222] o_flag_valid)
        else $error("Comparison exceeded one instruction time.");
    flag_val_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_flag_valid |-> (o_flag == $past(i_cmp_above)))
        else $error("Flag does not follow the comparator.");
    latch_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (route_d[2] && $past(route_d[2])) |-> $stable(latch_q[2]))
        else $error("Cut-off latch changed.");
    flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !o_flag_valid |-> $stable(o_flag))
        else $error("Flag changed outside a comparison.");
    valid_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_flag_valid |=> !o_flag_valid)
        else $error("Result pulse longer than one cycle.");
    switch_end_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_flag_valid |-> ($past(o_switch_on) && !o_switch_on))
        else $error("Switches not opened with the result.");
    read_start_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (state_q == adc_compare_pkg::ST_IDLE && i_flag_rd) |=> o_switch_on)
        else $error("Read did not start a comparison.");
    route_hot_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $onehot0(o_pin_route))
        else $error("More than one pin routed.");
    route_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !analog_q |-> (o_analog_mode == 6'h00))
        else $error("Pin in analog mode while port mode is set.");
    latch_follow_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !route_d[3] |=> (latch_q[3] == $past(i_pin_level[3])))
        else $error("Port latch does not follow its pin.");
endmodule // adc_compare_block
`default_nettype wire

// >>> sim/analog_src.sv
// Analog source model: one voltage per pin, compared with the block's reference.
// Assumes voltages and reference both in units of VDD/128.
`timescale 1ns/100ps
`default_nettype none
module analog_src (
    input  wire logic        i_clk,        // Block clock
    input  wire logic [47:0] i_volt,       // Six pin voltages
    input  wire logic [7:0]  i_ref_half,   // Reference level
    input  wire logic [5:0]  i_pin_route,  // One-hot routed pin
    output logic             o_cmp_above   // Input above reference
);
    logic       toggle_q = 1'b0;
    logic [7:0] v;
    always @(posedge i_clk) toggle_q <= ~toggle_q;
    // With no pin routed the comparator input floats, so its answer wanders.
    always_comb begin
        v = 8'h00;
        for (int i = 0; i < 6; i++) if (i_pin_route[i]) v = i_volt[i*8 +: 8];
        o_cmp_above = (i_pin_route == 6'h00) ? toggle_q : (v > i_ref_half);
    end
endmodule // analog_src
`default_nettype wire

// >>> sim/tb.sv
// Testbench for the converter compare stage.
// Assumes analog_src stands in for the analog pins.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
    logic i_clk = 1'b0, i_resetn = 1'b0, lvl_wr = 1'b0, ch_wr = 1'b0, an_en = 1'b0;
    logic rd = 1'b0, cmp, halt_en = 1'b0, f;
    adc_compare_pkg::reset_evt_t evt = 2'b00;
    logic [7:0] dbuf = 8'h00, ref_h;
    logic [2:0] ch = 3'h0;
    logic [5:0] pins = 6'h00, route, amode, latch;
    logic [47:0] volt = 48'h0;
    logic sw, flag, fvalid, halt;
    int fail_count = 0, checks = 0;
    initial forever #10 i_clk = ~i_clk;
    adc_compare_block u_adc_compare_block (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_reset_evt(evt), .i_level_wr(lvl_wr), .i_data_buffer(dbuf), .i_chan_wr(ch_wr),
        .i_chan_sel(ch), .i_analog_en(an_en), .i_flag_rd(rd), .i_cmp_above(cmp),
        .i_pin_level(pins), .i_key_halt_en(halt_en), .o_ref_half(ref_h),
        .o_pin_route(route), .o_analog_mode(amode), .o_input_latch(latch),
        .o_switch_on(sw), .o_flag(flag), .o_flag_valid(fvalid), .o_halt_release(halt));
    analog_src u_analog_src (.i_clk(i_clk), .i_volt(volt), .i_ref_half(ref_h),
        .i_pin_route(route), .o_cmp_above(cmp));
    task automatic end_sim();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic set_level(input logic [7:0] d);
        @(negedge i_clk) begin dbuf = d; lvl_wr = 1'b1; end
        @(negedge i_clk) lvl_wr = 1'b0;
    endtask
    task automatic set_chan(input logic [2:0] c);
        @(negedge i_clk) begin ch = c; ch_wr = 1'b1; an_en = 1'b1; end
        @(negedge i_clk) ch_wr = 1'b0;
    endtask
    task automatic compare(output logic r);
        int n;
        @(negedge i_clk) rd = 1'b1;
        @(negedge i_clk) rd = 1'b0;
        `CHK("switch on", 1'b1, sw)
        n = 1;
        while (fvalid !== 1'b1 && n < 300) begin @(negedge i_clk); n++; end
        `CHK("latency", 1'b1, n <= 223)
        `CHK("switch off", 1'b0, sw)
        r = flag;
        @(negedge i_clk);
        `CHK("valid pulse", 1'b0, fvalid)
    endtask
    task automatic t_reset();
        `CHK("mode", 6'h00, amode)
        `CHK("flag", 1'b0, flag)
    endtask
    task automatic t_level();
        for (int n = 0; n < 64; n++) begin
            set_level({2'b11, n[5:0]});
            `CHK("ref", (n == 0) ? 8'h00 : 8'(2 * n - 1), ref_h)
        end
    endtask
    task automatic t_compare();
        set_chan(3'h0);
        `CHK("route", 6'h01, route)
        set_level(8'h20);
        volt[7:0] = 8'h50;
        compare(f);
        `CHK("above", 1'b1, f)
        volt[7:0] = 8'h28;
        compare(f);
        `CHK("below", 1'b0, f)
        volt[7:0] = 8'h50;
        repeat (20) @(negedge i_clk);
        `CHK("no read", 1'b0, flag)
    endtask
    task automatic t_sar();
        logic [5:0] code;
        code = 6'h20;
        for (int k = 5; k >= 0; k--) begin
            set_level({2'b00, code});
            compare(f);
            if (f !== 1'b1) code[k] = 1'b0;
            if (k > 0) code[k-1] = 1'b1;
        end
        `CHK("sar", 6'h28, code)
    endtask
    task automatic t_key();
        @(negedge i_clk) pins = 6'h04;
        set_chan(3'h2);
        @(negedge i_clk) pins = 6'h00;
        repeat (3) @(negedge i_clk);
        `CHK("latch", 6'h04, latch)
        halt_en = 1'b1;
        @(negedge i_clk);
        `CHK("halt", 1'b1, halt)
        halt_en = 1'b0;
    endtask
    task automatic t_soft();
        for (int e = 1; e < 3; e++) begin
            set_chan(3'h1);
            `CHK("mode", 6'h02, amode)
            @(negedge i_clk) evt = 2'(e);
            @(negedge i_clk) evt = 2'b00;
            `CHK("mode", 6'h00, amode)
        end
        set_chan(3'h3);
        @(negedge i_clk) i_resetn = 1'b0;
        @(negedge i_clk) i_resetn = 1'b1;
        `CHK("por mode", 6'h00, amode)
        `CHK("por level", 8'h00, ref_h)
    endtask
    initial begin
        repeat (16) @(negedge i_clk);
        i_resetn = 1'b1;
        t_reset();
        t_level();
        t_compare();
        t_sar();
        t_key();
        t_soft();
        end_sim();
    end
    initial begin
        #(20 * 20000);
        fail_count++;
        end_sim();
    end
endmodule // tb
`default_nettype wire
